// >>> common/sfp_defines.svh
// Constants for the serial flash protocol selector.
// Assumes inclusion by bare name from the design files.
`ifndef SFP_DEFINES_SVH
`define SFP_DEFINES_SVH
`define SFP_NV_DUAL_BIT 2
`define SFP_NV_QUAD_BIT 3
`define SFP_EV_DUAL_BIT 6
`define SFP_EV_QUAD_BIT 7
`define SFP_BYTE_BITS 4'h8
`define SFP_EVCR_WRITE_CMD 8'h5a
`define SFP_LANES_1 2'h0
`define SFP_LANES_2 2'h1
`define SFP_LANES_4 2'h2
`define SFP_MASK_1 4'h2
`define SFP_MASK_2 4'h3
`define SFP_MASK_4 4'hf
`endif

// >>> common/sfp_pkg.sv
// Types for the serial flash protocol selector.
// Assumes nothing of its surroundings.
package sfp_pkg;
  typedef enum logic [1:0] {
    PROTO_EXT = 2'b00,
    PROTO_DUAL = 2'b01,
    PROTO_QUAD = 2'b10
  } proto_t;
endpackage

// >>> verilog/serial_flash_protocol_select.sv
// Serial interface front end of a flash device: pin sampling, protocol choice, shifting.
// Assumes sys_clk_in far faster than the serial clock and a core that decodes commands.
`timescale 1ns/1ps
`include "sfp_defines.svh"

// Behaviour
// R01: Both idle levels of the serial clock, low or high, are accepted as clock modes.
// R02: Incoming bits are captured on rising serial clock edges and outgoing bits launch on falls.
// R03: Both clock modes work in the extended, two-line and four-line protocols.
// R04: The output lines are driven only while chip select is active, otherwise released.
// R05: The protocol after a plain reset is extended, with the command byte on io_line_0.
// R06: In extended protocol address and data use one, two or four lines as the command says.
// R07: An enhanced volatile write with bit 7 at 1 and bit 6 at 0 selects two-line protocol.
// R08: A volatile choice reverts at power-on, on the rescue sequence or on a new volatile write.
// R09: Nonvolatile bit 2 at 0 with bit 3 at 1 makes every power-on start in two-line protocol.
// R10: An enhanced volatile write with bit 7 at 0 selects four-line protocol at once.
// R11: Nonvolatile bit 3 at 0 makes every power-on start in four-line protocol.
// R12: During a high-voltage program or erase in four-line mode extended protocol is used.
// R13: The host holds write-protect and hold at a defined level, never floating.
// R14: Each power-on loads the nonvolatile setting and later volatile writes act at once.
// R15: With bit 7 at 0 four-line protocol wins over two-line whatever bit 6 holds.
module serial_flash_protocol_select #(
  parameter logic [7:0] evcr_write_cmd = `SFP_EVCR_WRITE_CMD
) (
  // Clock and reset.
  input wire logic sys_clk_in,
  input wire logic sys_rst_in,
  // Serial pins.
  input wire logic serial_clk_in,
  input wire logic chip_select_n_in,
  input wire logic [3:0] io_in,
  output logic [3:0] io_out,
  output logic [3:0] io_oe_out,
  input wire logic vpp_high_in,
  // Configuration and core side.
  input wire logic [15:0] nv_config_in,
  input wire logic rescue_in,
  input wire logic pe_busy_in,
  input wire logic [1:0] ext_lanes_in,
  input wire logic [7:0] tx_data_in,
  input wire logic tx_enable_in,
  output logic tx_taken_out,
  output logic [7:0] cmd_out,
  output logic cmd_valid_out,
  output logic [7:0] rx_data_out,
  output logic rx_valid_out,
  // Status.
  output logic [1:0] proto_out,
  output logic clock_idle_level_out
);

  function automatic sfp_pkg::proto_t boot_proto(input logic [15:0] nv);
    if (!nv[`SFP_NV_QUAD_BIT]) begin
      boot_proto = sfp_pkg::PROTO_QUAD;
    end else if (!nv[`SFP_NV_DUAL_BIT]) begin
      boot_proto = sfp_pkg::PROTO_DUAL;
    end else begin
      boot_proto = sfp_pkg::PROTO_EXT;
    end
  endfunction

  function automatic sfp_pkg::proto_t evcr_proto(input logic [7:0] v);
    if (!v[`SFP_EV_QUAD_BIT]) begin
      evcr_proto = sfp_pkg::PROTO_QUAD;
    end else if (!v[`SFP_EV_DUAL_BIT]) begin
      evcr_proto = sfp_pkg::PROTO_DUAL;
    end else begin
      evcr_proto = sfp_pkg::PROTO_EXT;
    end
  endfunction

  // Number of lines in use for a protocol and phase.
  function automatic logic [3:0] lanes_of(input sfp_pkg::proto_t p, input logic cmd_phase,
                                          input logic [1:0] ext);
    if (p == sfp_pkg::PROTO_QUAD) begin
      lanes_of = 4'h4;
    end else if (p == sfp_pkg::PROTO_DUAL) begin
      lanes_of = 4'h2;
    end else if (cmd_phase) begin
      lanes_of = 4'h1;
    end else if (ext == `SFP_LANES_4) begin
      lanes_of = 4'h4;
    end else if (ext == `SFP_LANES_2) begin
      lanes_of = 4'h2;
    end else begin
      lanes_of = 4'h1;
    end
  endfunction

  // Pin synchroniser.
  logic [6:0] sync_1;
  logic [6:0] sync_2;
  logic sclk_d;
  logic cs_n_d;
  wire logic [6:0] raw_pins = {vpp_high_in, io_in, chip_select_n_in, serial_clk_in};

  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      sync_1 <= 7'h02;
      sync_2 <= 7'h02;
      sclk_d <= 1'b0;
      cs_n_d <= 1'b1;
    end else begin
      sync_1 <= raw_pins;
      sync_2 <= sync_1;
      sclk_d <= sync_2[0];
      cs_n_d <= sync_2[1];
    end
  end

  wire logic sclk_s = sync_2[0];
  wire logic cs_n_s = sync_2[1];
  wire logic [3:0] io_s = sync_2[5:2];
  wire logic vpp_s = sync_2[6];
  wire logic selected = ~cs_n_s;
  wire logic sclk_rise = sclk_s & ~sclk_d;
  wire logic sclk_fall = ~sclk_s & sclk_d;
  wire logic frame_start = ~cs_n_s & cs_n_d;
  wire logic frame_end = cs_n_s & ~cs_n_d;

  // Protocol selection.
  sfp_pkg::proto_t proto;
  logic boot_pending;
  logic [7:0] evcr_val;
  logic evcr_full;
  wire logic evcr_apply = frame_end & evcr_full;
  wire logic vpp_hold = (proto == sfp_pkg::PROTO_QUAD) & vpp_s & pe_busy_in;
  wire sfp_pkg::proto_t eff_proto = vpp_hold ? sfp_pkg::PROTO_EXT : proto; // R12

  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      proto <= sfp_pkg::PROTO_EXT; // R05
      boot_pending <= 1'b1;
    end else if (boot_pending) begin
      proto <= boot_proto(nv_config_in); // R09 R11 R14
      boot_pending <= 1'b0;
    end else if (rescue_in) begin
      proto <= sfp_pkg::PROTO_EXT; // R08
    end else if (evcr_apply) begin
      proto <= evcr_proto(evcr_val); // R07 R08 R10 R14 R15
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      proto_out <= sfp_pkg::PROTO_EXT;
    end else begin
      proto_out <= eff_proto;
    end
  end

  // Receive path.
  logic [7:0] shift;
  logic [3:0] bit_cnt;
  logic cmd_done;
  logic evcr_seen;
  wire logic [3:0] rx_lanes = lanes_of(eff_proto, ~cmd_done, ext_lanes_in); // R05 R06
  wire logic [7:0] next_shift = (rx_lanes == 4'h4) ? {shift[3:0], io_s} :
                                (rx_lanes == 4'h2) ? {shift[5:0], io_s[1:0]} :
                                {shift[6:0], io_s[0]};
  wire logic [3:0] next_cnt = bit_cnt + rx_lanes;
  wire logic byte_done = sclk_rise & selected & (next_cnt >= `SFP_BYTE_BITS);

  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in || !selected) begin
      shift <= 8'h00;
      bit_cnt <= 4'h0;
      cmd_done <= 1'b0;
      evcr_seen <= 1'b0;
    end else if (sclk_rise) begin
      shift <= next_shift; // R02
      bit_cnt <= byte_done ? 4'h0 : next_cnt;
      if (byte_done && !cmd_done) begin
        cmd_done <= 1'b1;
        evcr_seen <= (next_shift == evcr_write_cmd);
      end
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      cmd_out <= 8'h00;
      cmd_valid_out <= 1'b0;
      rx_data_out <= 8'h00;
      rx_valid_out <= 1'b0;
    end else begin
      cmd_valid_out <= byte_done & ~cmd_done;
      rx_valid_out <= byte_done & cmd_done;
      if (byte_done && !cmd_done) begin
        cmd_out <= next_shift;
      end
      if (byte_done && cmd_done) begin
        rx_data_out <= next_shift;
      end
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in || frame_start) begin
      evcr_val <= 8'hff;
      evcr_full <= 1'b0;
    end else if (byte_done && cmd_done && evcr_seen && !evcr_full) begin
      evcr_val <= next_shift;
      evcr_full <= 1'b1;
    end
  end

  // Transmit path.
  logic [7:0] tx_shift;
  logic [3:0] tx_cnt;
  wire logic [3:0] tx_lanes = lanes_of(eff_proto, 1'b0, ext_lanes_in); // R06
  wire logic [7:0] tx_src = (tx_cnt == 4'h0) ? tx_data_in : tx_shift;
  wire logic [3:0] tx_next_cnt = tx_cnt + tx_lanes;
  wire logic tx_step = sclk_fall & selected & tx_enable_in;
  wire logic [3:0] tx_bits = (tx_lanes == 4'h4) ? tx_src[7:4] :
                             (tx_lanes == 4'h2) ? {2'b00, tx_src[7:6]} :
                             {2'b00, tx_src[7], 1'b0};
  wire logic [3:0] tx_mask = (tx_lanes == 4'h4) ? `SFP_MASK_4 :
                             (tx_lanes == 4'h2) ? `SFP_MASK_2 : `SFP_MASK_1;
  wire logic [7:0] tx_rest = (tx_lanes == 4'h4) ? {tx_src[3:0], 4'h0} :
                             (tx_lanes == 4'h2) ? {tx_src[5:0], 2'b00} :
                             {tx_src[6:0], 1'b0};

  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in || !selected) begin
      tx_shift <= 8'h00;
      tx_cnt <= 4'h0;
    end else if (tx_step) begin
      tx_shift <= tx_rest;
      tx_cnt <= (tx_next_cnt >= `SFP_BYTE_BITS) ? 4'h0 : tx_next_cnt;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      io_out <= 4'h0;
      io_oe_out <= 4'h0;
      tx_taken_out <= 1'b0;
    end else begin
      tx_taken_out <= tx_step & (tx_cnt == 4'h0);
      if (!selected) begin
        io_oe_out <= 4'h0; // R04
      end else if (tx_step) begin
        io_out <= tx_bits; // R02
        io_oe_out <= tx_mask;
      end else if (sclk_fall) begin
        io_oe_out <= 4'h0;
      end
    end
  end

  // Clock mode seen at selection.
  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      clock_idle_level_out <= 1'b0;
    end else if (frame_start) begin
      clock_idle_level_out <= sclk_s; // R01 R03
    end
  end

  // Checks.
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (sys_rst_in);

  oe_deselect_a: assert property (cs_n_s |=> io_oe_out == 4'h0) // R04
    else $error("Output enabled while deselected.");
  launch_fall_a: assert property ($changed(io_out) |-> $past(sclk_fall)) // R02
    else $error("Output changed off a falling edge.");
  capture_rise_a: assert property (
    (selected && $past(selected) && $changed(bit_cnt) && bit_cnt != 4'h0)
    |-> $past(sclk_rise)) // R02
    else $error("Bit captured off a rising edge.");
  boot_load_a: assert property (boot_pending |=> proto == boot_proto($past(nv_config_in))) // R14
    else $error("Boot did not load the nonvolatile protocol.");
  quad_write_a: assert property (
    (!boot_pending && !rescue_in && evcr_apply && !evcr_val[7])
    |=> proto == sfp_pkg::PROTO_QUAD) // R10
    else $error("Volatile write did not select four lines.");
  dual_write_a: assert property (
    (!boot_pending && !rescue_in && evcr_apply && evcr_val[7:6] == 2'b10)
    |=> proto == sfp_pkg::PROTO_DUAL) // R07
    else $error("Volatile write did not select two lines.");
  revert_write_a: assert property (
    (!boot_pending && !rescue_in && evcr_apply && evcr_val[7:6] == 2'b11)
    |=> proto == sfp_pkg::PROTO_EXT) // R08
    else $error("Volatile write did not restore extended.");
  rescue_revert_a: assert property ((!boot_pending && rescue_in)
    |=> proto == sfp_pkg::PROTO_EXT) // R08
    else $error("Rescue did not restore extended.");
  vpp_extended_a: assert property (vpp_hold |=> proto_out == sfp_pkg::PROTO_EXT) // R12
    else $error("High-voltage cycle kept four lines.");
  cmd_line0_a: assert property (
    (eff_proto == sfp_pkg::PROTO_EXT && selected && !cmd_done && sclk_rise)
    |=> shift[0] == $past(io_s[0])) // R05
    else $error("Command bit not taken from line 0.");
  idle_level_a: assert property (frame_start |=> clock_idle_level_out == $past(sclk_s)) // R01
    else $error("Idle clock level not recorded.");

  mode3_quad_c: cover property (frame_start && sclk_s && proto == sfp_pkg::PROTO_QUAD); // R03
  mode0_dual_c: cover property (frame_start && !sclk_s && proto == sfp_pkg::PROTO_DUAL); // R03
  evcr_apply_c: cover property (evcr_apply);
  vpp_hold_c: cover property (vpp_hold ##1 !vpp_hold);

endmodule

// >>> verification/spi_master_model.sv
// Behavioural bus master that drives frames onto the serial pins.
// Assumes the bench resolves the shared io lines and feeds them back on io_in.
`timescale 1ns/1ps
module spi_master_model (
  // Serial pins.
  output logic sclk_out,
  output logic cs_n_out,
  output logic [3:0] io_out,
  input wire logic [3:0] io_in,
  // Last bits seen on io_line_1.
  output logic [7:0] got_out
);
  initial begin
    sclk_out = 1'b0;
    cs_n_out = 1'b1;
    io_out = 4'h5;
    got_out = 8'h00;
  end

  // Sends one byte MSB first on nl lines; data moves on falls, is taken on rises.
  task automatic xbyte(input logic [7:0] b, input int nl);
    for (int i = 0; i < 8 / nl; i++) begin
      sclk_out = 1'b0;
      io_out = ~io_out;
      if (nl == 1)
        io_out[0] = b[7];
      else if (nl == 2)
        io_out[1:0] = b[7:6];
      else
        io_out = b[7:4];
      b = b << nl;
      #62.5;
      sclk_out = 1'b1;
      got_out = {got_out[6:0], io_in[1]};
      #62.5;
    end
  endtask

  // One frame: command on lc lines, then nb data bytes on ld lines.
  task automatic frame(input logic clock_idle_level, input int lc, input logic [7:0] c,
                       input int ld, input int nb, input logic [7:0] d);
    sclk_out = clock_idle_level;
    #62.5;
    cs_n_out = 1'b0;
    #62.5;
    xbyte(c, lc);
    for (int k = 0; k < nb; k++)
      xbyte(d, ld);
    #62.5;
    sclk_out = clock_idle_level;
    #62.5;
    cs_n_out = 1'b1;
    io_out = ~io_out;
    #250;
  endtask
endmodule

// >>> verification/serial_flash_protocol_select_bench.sv
// Self-checking bench for the protocol selector.
// Assumes the master model drives the pins and the bench plays the core side.
`timescale 1ns/1ps
module serial_flash_protocol_select_bench;
  logic sys_clk_in = 1'b0;
  logic sys_rst_in = 1'b1;
  logic vpp_high_in = 1'b0;
  logic [15:0] nv_config_in = 16'hffff;
  logic rescue_in = 1'b0;
  logic pe_busy_in = 1'b0;
  logic [1:0] ext_lanes_in = 2'h0;
  logic [7:0] tx_data_in = 8'ha5;
  logic tx_enable_in = 1'b0;
  logic tx_on = 1'b0;
  logic taken_seen = 1'b0;
  logic sclk, cs_n, tx_taken, cmd_valid, rx_valid, idle_lvl;
  logic [3:0] m_io, io_o, io_oe, io_bus;
  logic [7:0] cmd, rx, got;
  logic [7:0] cap_cmd = 8'h00;
  logic [7:0] cap_rx = 8'h00;
  logic [1:0] proto;
  int n_mismatch = 0;
  int n_compared = 0;

  always #2.5 sys_clk_in = ~sys_clk_in;
  assign io_bus = (io_oe & io_o) | (~io_oe & m_io);

  spi_master_model u_master (.sclk_out(sclk), .cs_n_out(cs_n), .io_out(m_io),
    .io_in(io_bus), .got_out(got));
  serial_flash_protocol_select u_dut (.sys_clk_in(sys_clk_in), .sys_rst_in(sys_rst_in),
    .serial_clk_in(sclk), .chip_select_n_in(cs_n), .io_in(io_bus), .io_out(io_o),
    .io_oe_out(io_oe), .vpp_high_in(vpp_high_in), .nv_config_in(nv_config_in),
    .rescue_in(rescue_in), .pe_busy_in(pe_busy_in), .ext_lanes_in(ext_lanes_in),
    .tx_data_in(tx_data_in), .tx_enable_in(tx_enable_in), .tx_taken_out(tx_taken),
    .cmd_out(cmd), .cmd_valid_out(cmd_valid), .rx_data_out(rx), .rx_valid_out(rx_valid),
    .proto_out(proto), .clock_idle_level_out(idle_lvl));

  // Captures the one-cycle pulses and plays the core's send enable.
  always @(posedge sys_clk_in) begin
    if (cmd_valid === 1'b1)
      cap_cmd <= cmd;
    if (rx_valid === 1'b1)
      cap_rx <= rx;
    if (tx_taken === 1'b1)
      taken_seen <= 1'b1;
    if (cmd_valid === 1'b1 && tx_on)
      tx_enable_in <= #1 1'b1;
    else if (cs_n)
      tx_enable_in <= #1 1'b0;
  end

  task automatic print_verdict();
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    n_compared++;
    if (g !== e) begin
      n_mismatch++;
      $display("[FAIL] t=%0t got %h expected %h", $time, g, e);
    end
  endtask

  task automatic wait_proto(input sfp_pkg::proto_t p);
    int k;
    k = 0;
    while (proto !== p && k < 40) begin
      @(posedge sys_clk_in);
      #1;
      k++;
    end
    chk({6'h00, proto}, {6'h00, p});
    if (proto !== p)
      print_verdict();
  endtask

  task automatic do_reset(input logic [15:0] nv);
    @(posedge sys_clk_in);
    #1 sys_rst_in = 1'b1;
    nv_config_in = nv;
    repeat (10) @(posedge sys_clk_in);
    #1 sys_rst_in = 1'b0;
    repeat (6) @(posedge sys_clk_in);
    #1;
  endtask

  task automatic test_boot();
    do_reset(16'hfff7);
    wait_proto(sfp_pkg::PROTO_QUAD);
    do_reset(16'hfffb);
    wait_proto(sfp_pkg::PROTO_DUAL);
    do_reset(16'hfff3);
    wait_proto(sfp_pkg::PROTO_QUAD);
    do_reset(16'hffff);
    chk({6'h00, proto}, 8'h00);
    $display("test_boot done");
  endtask

  task automatic test_ext();
    u_master.frame(1'b0, 1, 8'h9f, 1, 0, 8'h00);
    chk(cap_cmd, 8'h9f);
    chk({7'h00, idle_lvl}, 8'h00);
    for (int n = 1; n < 3; n++) begin
      @(posedge sys_clk_in);
      #1 ext_lanes_in = n[1:0];
      u_master.frame(1'b0, 1, 8'h3b, 2 * n, 1, 8'hc6 + n[7:0]);
      chk(cap_rx, 8'hc6 + n[7:0]);
    end
    @(posedge sys_clk_in);
    #1 ext_lanes_in = 2'h0;
    tx_on = 1'b1;
    u_master.frame(1'b0, 1, 8'h0b, 1, 1, 8'h00);
    chk(got, 8'ha5);
    chk({4'h0, io_oe}, 8'h00);
    chk({7'h00, taken_seen}, 8'h01);
    tx_on = 1'b0;
    $display("test_ext done");
  endtask

  task automatic test_modes();
    u_master.frame(1'b1, 1, 8'h5a, 1, 1, 8'hbf);
    wait_proto(sfp_pkg::PROTO_DUAL);
    chk({7'h00, idle_lvl}, 8'h01);
    u_master.frame(1'b1, 2, 8'h9e, 2, 0, 8'h00);
    chk(cap_cmd, 8'h9e);
    u_master.frame(1'b0, 2, 8'h5a, 2, 1, 8'h3f);
    wait_proto(sfp_pkg::PROTO_QUAD);
    u_master.frame(1'b1, 4, 8'h6d, 4, 1, 8'h1c);
    chk(cap_cmd, 8'h6d);
    chk(cap_rx, 8'h1c);
    @(posedge sys_clk_in);
    #1 vpp_high_in = 1'b1;
    pe_busy_in = 1'b1;
    wait_proto(sfp_pkg::PROTO_EXT);
    u_master.frame(1'b0, 1, 8'h05, 1, 0, 8'h00);
    chk(cap_cmd, 8'h05);
    @(posedge sys_clk_in);
    #1 vpp_high_in = 1'b0;
    wait_proto(sfp_pkg::PROTO_QUAD);
    @(posedge sys_clk_in);
    #1 pe_busy_in = 1'b0;
    u_master.frame(1'b0, 4, 8'h5a, 4, 1, 8'hff);
    wait_proto(sfp_pkg::PROTO_EXT);
    u_master.frame(1'b0, 1, 8'h5a, 1, 1, 8'hbf);
    wait_proto(sfp_pkg::PROTO_DUAL);
    @(posedge sys_clk_in);
    #1 rescue_in = 1'b1;
    @(posedge sys_clk_in);
    #1 rescue_in = 1'b0;
    wait_proto(sfp_pkg::PROTO_EXT);
    $display("test_modes done");
  endtask

  initial begin
    test_boot();
    test_ext();
    test_modes();
    print_verdict();
  end
endmodule
